/* hdl/flash_adc_output_coding.sv */
// Function
// [R1] each sample strobe from outside starts one conversion of the input; one arriving while busy or with ctrlEn_q clear is dropped as a miss.
// [R2] a conversion completes in one decode step giving one word per strobe.
// [R3] each result is delivered as a 10-bit code on the result lines.
// [R4] upper nine bits come from 512 comparators, the lsb by interpolation.
// [R5] the over-range flag is set when the input exceeds positive full scale.
// [R6] low bits flip high inverts bits 0 to 8, low passes them unchanged.
// [R7] top bit flip high inverts bit 9, low passes it unchanged.
// [R8] the two flip controls select one of four output codings.
// [R9] the input is sampled a fixed aperture delay after the strobe rises.
// [R10] the strobe rising edge triggers conversion by latching comparators.
// [R11] capture logic takes the result only after the output delay passes.
// [R12] capture logic holds both flip controls fixed during conversions.
//
// The placing of the registers and the address-and-strobe port were decided locally.
module flash_adc_output_coding
  import flash_adc_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire logic              clkEn,
  input  wire logic              sampleStrobe,
  input  wire logic [COMP_N-1:0] compBank,
  input  wire logic [COMP_N-1:0] interpBank,
  input  wire logic              overComp,
  input  wire logic              lowBitsFlip,
  input  wire logic              topBitFlip,
  output logic [CODE_W-1:0]      resultBits,
  output logic                   overRangeFlag,
  output logic                   resultValid,
  input  wire logic              resultReady,
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [DATA_W-1:0] regWrData,
  input  wire logic              regWrStb,
  input  wire logic              regRdStb,
  output logic [DATA_W-1:0]      regRdData
);

  // pin synchronisers
  logic              strobeMeta_q;
  logic              strobeSync_q;
  logic              strobeLast_q;
  logic [COMP_N-1:0] compMeta_q;
  logic [COMP_N-1:0] compSync_q;
  logic [COMP_N-1:0] interpMeta_q;
  logic [COMP_N-1:0] interpSync_q;
  logic              overMeta_q;
  logic              overSync_q;
  logic [1:0]        flipMeta_q;
  logic [1:0]        flipSync_q;
  logic              strobeRise;

  // conversion state
  conv_e             state_q;
  logic [3:0]        apCnt_q;
  logic [COMP_N-1:0] latchComp_q;
  logic [COMP_N-1:0] latchInterp_q;
  logic              latchOver_q;
  result_s           pend_q;
  logic [CODE_W-1:0] rawCode;

  // registers
  logic              ctrlEn_q;
  logic [CNT_W-1:0]  convCnt_q;
  logic [CNT_W-1:0]  missCnt_q;
  result_s           lastRes_q;

  // buffer
  logic              bufInReady;
  logic              bufOutValid;
  logic              bufOutReady;
  result_s           bufOutData;

  localparam logic [3:0] AP_LOAD = 4'(APERTURE_CYC - 1);

  function automatic logic [UPPER_W-1:0] thermoLevel(
    input logic [COMP_N-1:0] t
  );
    logic [UPPER_W+1:0] n;
    n = '0;
    for (int i = 0; i < COMP_N; i++) begin
      n = n + (UPPER_W+2)'(t[i]);
    end
    if (n > (UPPER_W+2)'(COMP_N - 1)) begin
      thermoLevel = '1;
    end else begin
      thermoLevel = n[UPPER_W-1:0];
    end
  endfunction : thermoLevel

  function automatic logic [CODE_W-1:0] applyCoding(
    input logic [CODE_W-1:0] c,
    input logic              lowF,
    input logic              topF
  );
    applyCoding = {c[CODE_W-1] ^ topF, c[UPPER_W-1:0] ^ {UPPER_W{lowF}}};
  endfunction : applyCoding

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      strobeMeta_q <= 1'b0;
      strobeSync_q <= 1'b0;
      strobeLast_q <= 1'b0;
      overMeta_q   <= 1'b0;
      overSync_q   <= 1'b0;
      flipMeta_q   <= '0;
      flipSync_q   <= '0;
      compMeta_q   <= '0;
      compSync_q   <= '0;
      interpMeta_q <= '0;
      interpSync_q <= '0;
    end else if (clkEn) begin
      strobeMeta_q <= sampleStrobe;
      strobeSync_q <= strobeMeta_q;
      strobeLast_q <= strobeSync_q;
      overMeta_q   <= overComp;
      overSync_q   <= overMeta_q;
      flipMeta_q   <= {topBitFlip, lowBitsFlip};
      flipSync_q   <= flipMeta_q;
      compMeta_q   <= compBank;
      compSync_q   <= compMeta_q;
      interpMeta_q <= interpBank;
      interpSync_q <= interpMeta_q;
    end
  end

  assign strobeRise = strobeSync_q && !strobeLast_q; // R1 R10

  // upper bits from comparator level, lsb interpolated
  assign rawCode = {thermoLevel(latchComp_q),
                    latchInterp_q[thermoLevel(latchComp_q)]}; // R4

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      apCnt_q <= '0;
    end else if (clkEn) begin
      case (state_q)
        ST_IDLE: begin
          if (strobeRise && ctrlEn_q) begin
            state_q <= ST_APERTURE; // R1
            apCnt_q <= AP_LOAD; // R9
          end
        end
        ST_APERTURE: begin
          if (apCnt_q == '0) begin
            state_q <= ST_DECODE; // R9
          end else begin
            apCnt_q <= apCnt_q - 4'h1;
          end
        end
        ST_DECODE: begin
          state_q <= ST_PUSH; // R2
        end
        ST_PUSH: begin
          if (bufInReady) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      latchComp_q   <= '0;
      latchInterp_q <= '0;
      latchOver_q   <= 1'b0;
    end else if (clkEn && state_q == ST_APERTURE && apCnt_q == '0) begin
      latchComp_q   <= compSync_q; // R10
      latchInterp_q <= interpSync_q; // R10
      latchOver_q   <= overSync_q; // R5
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_q <= '0;
    end else if (clkEn && state_q == ST_DECODE) begin
      pend_q.code      <= applyCoding(rawCode, flipSync_q[0],
                                      flipSync_q[1]); // R6 R7 R8
      pend_q.overRange <= latchOver_q; // R5
    end
  end

  result_buffer #(
    .WIDTH (RES_W),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .clkEn    (clkEn),
    .inValid  (state_q == ST_PUSH),
    .inReady  (bufInReady),
    .inData   (pend_q),
    .outValid (bufOutValid),
    .outReady (bufOutReady),
    .outData  (bufOutData)
  );

  assign bufOutReady = !resultValid || resultReady;

  // output stage, held until taken
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      resultBits    <= '0;
      overRangeFlag <= 1'b0;
      resultValid   <= 1'b0;
    end else if (clkEn && bufOutReady) begin
      resultValid <= bufOutValid; // R11
      if (bufOutValid) begin
        resultBits    <= bufOutData.code; // R3
        overRangeFlag <= bufOutData.overRange; // R5
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      convCnt_q <= '0;
      missCnt_q <= '0;
      lastRes_q <= '0;
    end else if (clkEn) begin
      if (state_q == ST_PUSH && bufInReady) begin
        convCnt_q <= convCnt_q + CNT_W'(1);
        lastRes_q <= pend_q;
      end
      if (strobeRise && (state_q != ST_IDLE || !ctrlEn_q)) begin
        missCnt_q <= missCnt_q + CNT_W'(1);
      end
    end
  end

  // register port
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrlEn_q <= CTRL_RESET;
    end else if (clkEn && regWrStb && regAddr == REG_CTRL) begin
      ctrlEn_q <= regWrData[CTRL_EN_BIT];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdData <= '0;
    end else if (clkEn) begin
      regRdData <= '0;
      if (regRdStb) begin
        case (regAddr)
          REG_CTRL: begin
            regRdData[CTRL_EN_BIT] <= ctrlEn_q;
          end
          REG_STATUS: begin
            regRdData[STAT_CODE_LSB +: CODE_W] <= lastRes_q.code;
            regRdData[STAT_OVR_BIT]  <= lastRes_q.overRange;
            regRdData[STAT_BUSY_BIT] <= (state_q != ST_IDLE);
            regRdData[STAT_FULL_BIT] <= !bufInReady;
          end
          REG_CONV: begin
            regRdData[CNT_W-1:0] <= convCnt_q;
          end
          REG_MISS: begin
            regRdData[CNT_W-1:0] <= missCnt_q;
          end
          default: begin
            regRdData <= '0;
          end
        endcase
      end
    end
  end

  // checks
  sequence sStart;
    state_q == ST_IDLE && strobeRise && ctrlEn_q && clkEn;
  endsequence

  sequence sAperture;
    clkEn [*2];
  endsequence

  sequence sDecode;
    state_q == ST_DECODE && clkEn;
  endsequence

  AST_APERTURE: assert property ( // R9
    @(posedge sys_clk) disable iff (!rst_n)
    sStart ##1 sAperture |=> state_q == ST_DECODE)
    else $error("aperture delay not two cycles");

  AST_START: assert property ( // R1
    @(posedge sys_clk) disable iff (!rst_n)
    sStart |=> state_q == ST_APERTURE && apCnt_q == AP_LOAD)
    else $error("strobe did not start conversion");

  AST_LATCH: assert property ( // R10
    @(posedge sys_clk) disable iff (!rst_n)
    state_q == ST_APERTURE && apCnt_q == '0 && clkEn
      |=> latchComp_q == $past(compSync_q)
          && latchInterp_q == $past(interpSync_q))
    else $error("comparators not latched");

  AST_ONE_STEP: assert property ( // R2
    @(posedge sys_clk) disable iff (!rst_n)
    sDecode |=> state_q == ST_PUSH)
    else $error("decode took more than one step");

  AST_LEVEL_LOW: assert property ( // R4
    @(posedge sys_clk) disable iff (!rst_n)
    state_q == ST_DECODE && clkEn && rawCode[CODE_W-1:1] != '0
      |-> latchComp_q[rawCode[CODE_W-1:1] - UPPER_W'(1)])
    else $error("comparator below level not tripped");

  AST_LEVEL_HIGH: assert property ( // R4
    @(posedge sys_clk) disable iff (!rst_n)
    state_q == ST_DECODE && clkEn && !latchComp_q[COMP_N-1]
      |-> !latchComp_q[rawCode[CODE_W-1:1]])
    else $error("comparator at level tripped");

  AST_FULL_SCALE: assert property ( // R4
    @(posedge sys_clk) disable iff (!rst_n)
    state_q == ST_DECODE && clkEn && latchComp_q[COMP_N-1]
      |-> rawCode[CODE_W-1:1] == '1)
    else $error("full scale level not clamped");

  AST_LOW_FLIP: assert property ( // R6
    @(posedge sys_clk) disable iff (!rst_n)
    sDecode |=> pend_q.code[UPPER_W-1:0]
      == ($past(rawCode[UPPER_W-1:0]) ^ {UPPER_W{$past(flipSync_q[0])}}))
    else $error("low bits coding wrong");

  AST_TOP_FLIP: assert property ( // R7
    @(posedge sys_clk) disable iff (!rst_n)
    sDecode |=> pend_q.code[CODE_W-1]
      == ($past(rawCode[CODE_W-1]) ^ $past(flipSync_q[1])))
    else $error("top bit coding wrong");

  AST_OVER: assert property ( // R5
    @(posedge sys_clk) disable iff (!rst_n)
    sDecode |=> pend_q.overRange == $past(latchOver_q))
    else $error("over-range flag lost");

  AST_HOLD: assert property ( // R3
    @(posedge sys_clk) disable iff (!rst_n)
    resultValid && !resultReady
      |=> resultValid && $stable(resultBits) && $stable(overRangeFlag))
    else $error("result dropped while stalled");

endmodule : flash_adc_output_coding

/* hdl/flash_adc_pkg.sv */
package flash_adc_pkg;

  localparam int CODE_W        = 10;
  localparam int UPPER_W       = 9;
  localparam int COMP_N        = 512;
  localparam int DATA_W        = 32;
  localparam int ADDR_W        = 8;
  localparam int CNT_W         = 16;

  // aperture delay
  localparam int CLK_MHZ       = 200;
  localparam int APERTURE_NS   = 10;
  localparam int APERTURE_CYC  =
    (APERTURE_NS * CLK_MHZ + 999) / 1000 < 1 ? 1 :
    (APERTURE_NS * CLK_MHZ + 999) / 1000;

  // register map
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_CONV   = 8'h08;
  localparam logic [7:0] REG_MISS   = 8'h0C;

  localparam int CTRL_EN_BIT   = 0;
  localparam logic CTRL_RESET  = 1'b1;
  localparam int STAT_CODE_LSB = 0;
  localparam int STAT_OVR_BIT  = 10;
  localparam int STAT_BUSY_BIT = 11;
  localparam int STAT_FULL_BIT = 12;

  localparam int BUF_DEPTH     = 2;

  typedef struct packed {
    logic                overRange;
    logic [CODE_W-1:0]   code;
  } result_s;

  localparam int RES_W = $bits(result_s);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_APERTURE,
    ST_DECODE,
    ST_PUSH
  } conv_e;

endpackage : flash_adc_pkg

/* hdl/result_buffer.sv */
module result_buffer
  import flash_adc_pkg::*;
#(
  parameter int WIDTH = RES_W,
  parameter int DEPTH = BUF_DEPTH
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             clkEn,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] DEPTH_C = (PW+1)'(DEPTH);
  localparam logic [PW-1:0] LAST_C = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wrPtr_q;
  logic [PW-1:0]    rdPtr_q;
  logic [PW:0]      fill_q;
  logic             doWr;
  logic             doRd;

  assign inReady  = (fill_q != DEPTH_C);
  assign outValid = (fill_q != '0);
  assign outData  = mem_q[rdPtr_q];
  assign doWr     = clkEn && inValid && inReady;
  assign doRd     = clkEn && outValid && outReady;

  function automatic logic [PW-1:0] nextPtr(input logic [PW-1:0] p);
    nextPtr = (p == LAST_C) ? '0 : p + PW'(1);
  endfunction : nextPtr

  always_ff @(posedge sys_clk) begin
    if (doWr) begin
      mem_q[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end else begin
      if (doWr) begin
        wrPtr_q <= nextPtr(wrPtr_q);
      end
      if (doRd) begin
        rdPtr_q <= nextPtr(rdPtr_q);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fill_q <= '0;
    end else if (doWr && !doRd) begin
      fill_q <= fill_q + (PW+1)'(1);
    end else if (doRd && !doWr) begin
      fill_q <= fill_q - (PW+1)'(1);
    end
  end

endmodule : result_buffer

/* tb/capture_model.sv */
module capture_model
  import flash_adc_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire logic              fire,
  input  wire logic              stall,
  input  wire logic              resultValid,
  input  wire logic [CODE_W-1:0] resultBits,
  input  wire logic              overRangeFlag,
  output logic                   sampleStrobe,
  output logic                   resultReady,
  output logic                   gotStb,
  output result_s                gotWord
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [1:0] highCnt_q;

  // one strobe pulse per request, three cycles high
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      highCnt_q <= 2'h0;
    end else if (fire) begin
      highCnt_q <= 2'h3;
    end else if (highCnt_q != 2'h0) begin
      highCnt_q <= highCnt_q - 2'h1;
    end
  end
  assign sampleStrobe = (highCnt_q != 2'h0);
  assign resultReady  = !stall;

  // latch a word only at a handshake edge
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      gotStb  <= 1'b0;
      gotWord <= '0;
    end else begin
      gotStb <= resultValid && resultReady;
      if (resultValid && resultReady) begin
        gotWord <= {overRangeFlag, resultBits};
      end
    end
  end
endmodule : capture_model

/* tb/tb_top.sv */
module tb_top
  import flash_adc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic              sys_clk;
  logic              rst_n;
  logic              clkEn;
  logic [COMP_N-1:0] compBank;
  logic [COMP_N-1:0] interpBank;
  logic              overComp;
  logic              lowBitsFlip;
  logic              topBitFlip;
  logic [CODE_W-1:0] resultBits;
  logic              overRangeFlag;
  logic              resultValid;
  logic              resultReady;
  logic [ADDR_W-1:0] regAddr;
  logic [DATA_W-1:0] regWrData;
  logic              regWrStb;
  logic              regRdStb;
  logic [DATA_W-1:0] regRdData;
  logic              fire;
  logic              stall;
  logic              sampleStrobe;
  logic              gotStb;
  result_s           gotWord;
  result_s           expQ[$];
  result_s           e;
  result_s           lastExp;
  logic [31:0]       d;
  int                badCount;
  int                checksDone;
  int                gotN;
  int                w;

  flash_adc_output_coding flash_adc_output_coding_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn),
    .sampleStrobe(sampleStrobe), .compBank(compBank),
    .interpBank(interpBank), .overComp(overComp),
    .lowBitsFlip(lowBitsFlip), .topBitFlip(topBitFlip),
    .resultBits(resultBits), .overRangeFlag(overRangeFlag),
    .resultValid(resultValid), .resultReady(resultReady),
    .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
    .regRdStb(regRdStb), .regRdData(regRdData));

  capture_model capture_model_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .fire(fire), .stall(stall),
    .resultValid(resultValid), .resultBits(resultBits),
    .overRangeFlag(overRangeFlag), .sampleStrobe(sampleStrobe),
    .resultReady(resultReady), .gotStb(gotStb), .gotWord(gotWord));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] seen);
    checksDone++;
    if (seen !== exp) begin
      badCount++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checksDone, badCount);
    if (badCount == 0 && checksDone > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict

  function automatic result_s exp_word(input int k,
      input logic [COMP_N-1:0] ib, input logic lf, input logic tf,
      input logic ov);
    int lv;
    lv = (k > COMP_N - 1) ? COMP_N - 1 : k;
    exp_word.code = {lv[8] ^ tf, lv[7:0] ^ {8{lf}}, ib[lv] ^ lf};
    exp_word.overRange = ov;
  endfunction : exp_word

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    regAddr   <= a;
    regWrData <= v;
    regWrStb  <= 1'b1;
    @(posedge sys_clk);
    regWrStb  <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    regAddr  <= a;
    regRdStb <= 1'b1;
    @(posedge sys_clk);
    regRdStb <= 1'b0;
    @(negedge sys_clk);
    v = regRdData;
  endtask : reg_rd

  task automatic pulse;
    @(posedge sys_clk);
    fire <= 1'b1;
    @(posedge sys_clk);
    fire <= 1'b0;
  endtask : pulse

  task automatic conv(input int k, input logic lf, input logic tf,
                      input bit slow);
    logic [COMP_N-1:0] th;
    logic [COMP_N-1:0] ib;
    logic              ov;
    int                n0;
    int                t;
    th = '0;
    for (int i = 0; i < k; i++) th[i] = 1'b1;
    for (int j = 0; j < COMP_N / 32; j++) ib[j*32 +: 32] = $urandom;
    ov = 1'($urandom_range(0, 1));
    @(posedge sys_clk);
    compBank    <= th;
    interpBank  <= ib;
    overComp    <= ov;
    lowBitsFlip <= lf;
    topBitFlip  <= tf;
    lastExp = exp_word(k, ib, lf, tf, ov);
    expQ.push_back(lastExp);
    repeat (4) @(posedge sys_clk);
    n0 = gotN;
    pulse();
    if (slow) begin
      repeat (20) @(posedge sys_clk);
    end else begin
      t = 0;
      while (gotN == n0 && t < 60) begin
        @(posedge sys_clk);
        t++;
      end
      check("one word per strobe", 32'h1, 32'(gotN - n0));
    end
  endtask : conv

  // compare each captured word against the oldest expectation
  always @(posedge sys_clk) begin
    if (gotStb === 1'b1) begin
      gotN++;
      if (expQ.size() == 0) begin
        check("spare word", 32'h0, 32'h1);
      end else begin
        e = expQ.pop_front();
        check("result code", 32'(e.code), 32'(gotWord.code));
        check("over range", 32'(e.overRange), 32'(gotWord.overRange));
      end
    end
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    badCount++;
    print_verdict();
  end

  initial begin
    rst_n = 1'b0;
    clkEn = 1'b1;
    compBank = '0;
    interpBank = '0;
    overComp = 1'b0;
    lowBitsFlip = 1'b0;
    topBitFlip = 1'b0;
    regAddr = '0;
    regWrData = '0;
    regWrStb = 1'b0;
    regRdStb = 1'b0;
    fire = 1'b0;
    stall = 1'b0;
    badCount = 0;
    checksDone = 0;
    gotN = 0;
    void'($urandom(86));
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    reg_rd(REG_CTRL, d);
    check("ctrl reset", 32'h1, d);
    reg_rd(REG_STATUS, d);
    check("status reset", 32'h0, d);
    reg_rd(REG_CONV, d);
    check("conv reset", 32'h0, d);
    reg_rd(8'h10, d);
    check("unmapped read", 32'h0, d);
    $display("test reset values done");
    for (int m = 0; m < 4; m++) begin
      conv(0, m[0], m[1], 1'b0);
      conv(COMP_N - 1, m[0], m[1], 1'b0);
      conv(COMP_N, m[0], m[1], 1'b0);
      conv($urandom_range(1, COMP_N - 2), m[0], m[1], 1'b0);
    end
    reg_rd(REG_CONV, d);
    check("conv count", 32'd16, {16'h0, d[15:0]});
    reg_rd(REG_STATUS, d);
    check("status code", 32'(lastExp.code), 32'(d[9:0]));
    check("status over", 32'(lastExp.overRange), 32'(d[STAT_OVR_BIT]));
    $display("test codings done");
    reg_wr(REG_CTRL, 32'h0);
    w = gotN;
    pulse();
    repeat (20) @(posedge sys_clk);
    check("no word disabled", 32'(w), 32'(gotN));
    reg_rd(REG_MISS, d);
    check("miss count", 32'h1, {16'h0, d[15:0]});
    reg_wr(REG_CTRL, 32'h1);
    $display("test disable done");
    stall <= 1'b1;
    for (int s = 0; s < 3; s++) conv($urandom_range(0, COMP_N), 1'b0,
                                      1'b0, 1'b1);
    reg_rd(REG_STATUS, d);
    check("buffer full", 32'h1, 32'(d[STAT_FULL_BIT]));
    check("held while stalled", 32'(w), 32'(gotN));
    w = 0;
    while (expQ.size() != 0 && w < 500) begin
      @(posedge sys_clk);
      stall <= 1'($urandom_range(0, 1));
      w++;
    end
    stall <= 1'b0;
    check("drained", 32'h0, 32'(expQ.size()));
    reg_rd(REG_CONV, d);
    check("conv total", 32'd19, {16'h0, d[15:0]});
    $display("test stall done");
    print_verdict();
  end
endmodule : tb_top
